// *** verilog/crc_top.sv ***
// Notes on behaviour
// - In sleep the comparators and change interrupt keep running when active.
// - Waking from sleep leaves the comparator control register unchanged.
// - Reset returns comparator control to reset state, mode 111, comparators off.
// - After reset comparator pins are analog; role then set by external config.
// - Ladder has two ranges of sixteen levels each via four-bit tap.
// - Bit 7 powers the ladder on when set, down when clear.
// - Bit 6 drives the ladder onto its pin, overriding the port_f5_direction input.
// - Bit 5 selects range: 1 is zero-based /24, 0 is quarter-based /32.
// - Bit 4 selects source: 1 external reference pair, 0 supply rails.
// - Bits 3..0 hold the tap value 0 to 15 within active range.
// - Ladder works whether or not the comparators are enabled.
// - Change flag sets on any comparator output change, except in mode 111 (comparators off).
// - Internal reference reaches comparators only in mode 110, positive inputs.
// - The two comparator result bits are readable and read-only.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
module crc_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        clk_en,
	input  wire logic        sleep_active,
	input  wire logic        comp1_raw,
	input  wire logic        comp2_raw,
	input  wire logic        port_f5_direction,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [2:0]       comparator_mode_field,
	output logic             comp1_invert,
	output logic             comp2_invert,
	output logic             input_switch,
	output logic             comp_pins_analog,
	output logic             ref_to_comparators,
	output logic             ladder_power_on,
	output logic             ladder_pin_drive,
	output logic             ladder_pin_oe_n,
	output logic             ladder_range_select,
	output logic             ladder_source_select,
	output logic [3:0]       ladder_tap_value,
	output logic             comparator_change_flag,
	output logic             wake_request,
	output logic             irq
);
	typedef enum logic [2:0] {
		WR_IDLE = 3'b001,
		WR_RESP = 3'b010,
		WR_HOLD = 3'b100
	} crc_wr_t;

	crc_wr_t     wr_state_q;
	logic        aw_got_q;
	logic        w_got_q;
	logic [3:0]  waddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic [5:0]  comp_ctrl_q;
	logic [7:0]  ladder_ctrl_q;
	logic [1:0]  results_q;
	logic [1:0]  irq_status_q;
	logic [1:0]  irq_mask_q;
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        irq_q;
	logic        awready_q;
	logic        wready_q;

	function automatic logic known_addr(input logic [3:0] a);
		known_addr = (a == crc_pkg::OFS_COMP_CTRL) || (a == crc_pkg::OFS_LADDER_CTRL) ||
			(a == crc_pkg::OFS_IRQ_STATUS) || (a == crc_pkg::OFS_IRQ_MASK);
	endfunction

	wire       aw_take  = s_axi_awvalid && !aw_got_q && (wr_state_q == WR_IDLE);
	wire       w_take   = s_axi_wvalid && !w_got_q && (wr_state_q == WR_IDLE);
	wire       aw_have  = aw_got_q || aw_take;
	wire       w_have   = w_got_q || w_take;
	wire [3:0] wa       = aw_got_q ? waddr_q : s_axi_awaddr;
	wire [31:0] wd      = w_got_q ? wdata_q : s_axi_wdata;
	wire [3:0] ws       = w_got_q ? wstrb_q : s_axi_wstrb;
	wire       wr_fire  = (wr_state_q == WR_IDLE) && aw_have && w_have;
	wire       wr_lane0 = wr_fire && ws[0];
	wire       wr_comp  = wr_lane0 && (wa == crc_pkg::OFS_COMP_CTRL);
	wire       wr_lad   = wr_lane0 && (wa == crc_pkg::OFS_LADDER_CTRL);
	wire       wr_stat  = wr_lane0 && (wa == crc_pkg::OFS_IRQ_STATUS);
	wire       wr_mask  = wr_lane0 && (wa == crc_pkg::OFS_IRQ_MASK);
	wire       rd_fire  = s_axi_arvalid && arready_q && !rvalid_q;
	wire       rd_stat  = rd_fire && (s_axi_araddr == crc_pkg::OFS_IRQ_STATUS);

	wire [1:0] results_now = {comp2_raw, comp1_raw};
	wire       change_evt  = (results_now != results_q);
	wire       mode_off    = (comp_ctrl_q[2:0] == crc_pkg::MODE_ALL_OFF);
	wire [1:0] stat_set    = {1'b0, change_evt && !mode_off};
	// Status: sticky, cleared by read; set wins
	wire [1:0] stat_d      = (rd_stat ? 2'h0 : irq_status_q) | stat_set;
	wire [7:0] comp_rd     = {results_q, comp_ctrl_q};
	wire [7:0] rd_byte     = (s_axi_araddr == crc_pkg::OFS_COMP_CTRL)   ? comp_rd :
	                         (s_axi_araddr == crc_pkg::OFS_LADDER_CTRL) ? ladder_ctrl_q :
	                         (s_axi_araddr == crc_pkg::OFS_IRQ_STATUS)  ? {6'h00, irq_status_q} :
	                         (s_axi_araddr == crc_pkg::OFS_IRQ_MASK)    ? {6'h00, irq_mask_q} : 8'h00;

	// Write channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_q <= WR_IDLE;
			aw_got_q   <= 1'b0;
			w_got_q    <= 1'b0;
			waddr_q    <= 4'h0;
			wdata_q    <= 32'h0000_0000;
			wstrb_q    <= 4'h0;
			bvalid_q   <= 1'b0;
			bresp_q    <= crc_pkg::RESP_OKAY;
			awready_q  <= 1'b1;
			wready_q   <= 1'b1;
		end else if (clk_en) begin
			case (wr_state_q)
				WR_IDLE: begin
					if (wr_fire) begin
						aw_got_q   <= 1'b0;
						w_got_q    <= 1'b0;
						bvalid_q   <= 1'b1;
						bresp_q    <= known_addr(wa) ? crc_pkg::RESP_OKAY : crc_pkg::RESP_SLVERR;
						wr_state_q <= WR_RESP;
						awready_q  <= 1'b0;
						wready_q   <= 1'b0;
					end else begin
						// Ready drops once a half is held
						awready_q <= !aw_have;
						wready_q  <= !w_have;
						if (aw_take) begin
							aw_got_q <= 1'b1;
							waddr_q  <= s_axi_awaddr;
						end
						if (w_take) begin
							w_got_q <= 1'b1;
							wdata_q <= s_axi_wdata;
							wstrb_q <= s_axi_wstrb;
						end
					end
				end
				WR_RESP: begin
					if (s_axi_bready) begin
						bvalid_q   <= 1'b0;
						wr_state_q <= WR_HOLD;
					end
				end
				WR_HOLD: begin
					wr_state_q <= WR_IDLE;
					awready_q  <= 1'b1;
					wready_q   <= 1'b1;
				end
				default: begin
					wr_state_q <= WR_IDLE;
					awready_q  <= 1'b1;
					wready_q   <= 1'b1;
				end
			endcase
		end
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= crc_pkg::RESP_OKAY;
		end else if (clk_en) begin
			arready_q <= !rvalid_q && !rd_fire;
			if (rd_fire) begin
				rvalid_q <= 1'b1;
				rdata_q  <= {24'h00_0000, rd_byte};
				rresp_q  <= known_addr(s_axi_araddr) ? crc_pkg::RESP_OKAY : crc_pkg::RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			comp_ctrl_q   <= crc_pkg::COMP_CTRL_RESET;
			ladder_ctrl_q <= crc_pkg::LADDER_CTRL_RESET;
			irq_mask_q    <= crc_pkg::IRQ_RESET;
		end else if (clk_en) begin
			if (wr_comp)
				comp_ctrl_q <= wd[5:0];
			if (wr_lad)
				ladder_ctrl_q <= wd[7:0];
			if (wr_mask)
				irq_mask_q <= wd[1:0];
		end
	end

	// Result sampling and change flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			results_q    <= 2'h0;
			irq_status_q <= crc_pkg::IRQ_RESET;
			irq_q        <= 1'b0;
			wake_request <= 1'b0;
		end else if (clk_en) begin
			results_q    <= mode_off ? 2'h0 : results_now;
			irq_status_q <= wr_stat ? (stat_d & ~wd[1:0]) | stat_set : stat_d;
			irq_q        <= |(stat_d & irq_mask_q);
			wake_request <= sleep_active && |(stat_d & irq_mask_q);
		end
	end

	// Static analog controls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			comparator_mode_field <= crc_pkg::MODE_ALL_OFF;
			comp1_invert          <= 1'b0;
			comp2_invert          <= 1'b0;
			input_switch          <= 1'b0;
			comp_pins_analog      <= 1'b1;
			ref_to_comparators    <= 1'b0;
			ladder_power_on       <= 1'b0;
			ladder_pin_drive      <= 1'b0;
			ladder_pin_oe_n       <= 1'b1;
			ladder_range_select   <= 1'b0;
			ladder_source_select  <= 1'b0;
			ladder_tap_value      <= 4'h0;
		end else if (clk_en) begin
			comparator_mode_field <= comp_ctrl_q[2:0];
			comp1_invert          <= comp_ctrl_q[crc_pkg::COMP1_INV_BIT];
			comp2_invert          <= comp_ctrl_q[crc_pkg::COMP2_INV_BIT];
			input_switch          <= comp_ctrl_q[crc_pkg::INPUT_SWITCH_BIT];
			comp_pins_analog      <= 1'b1;
			ref_to_comparators    <= (comp_ctrl_q[2:0] == crc_pkg::MODE_REF_INTERNAL);
			ladder_power_on       <= ladder_ctrl_q[crc_pkg::LADDER_POWER_BIT];
			ladder_pin_drive      <= ladder_ctrl_q[crc_pkg::LADDER_PIN_BIT];
			ladder_pin_oe_n       <= ladder_ctrl_q[crc_pkg::LADDER_PIN_BIT] ? 1'b0 : port_f5_direction;
			ladder_range_select   <= ladder_ctrl_q[crc_pkg::LADDER_RANGE_BIT];
			ladder_source_select  <= ladder_ctrl_q[crc_pkg::LADDER_SOURCE_BIT];
			ladder_tap_value      <= ladder_ctrl_q[3:0];
		end
	end

	assign s_axi_awready          = awready_q;
	assign s_axi_wready           = wready_q;
	assign s_axi_bvalid           = bvalid_q;
	assign s_axi_bresp            = bresp_q;
	assign s_axi_arready          = arready_q;
	assign s_axi_rvalid           = rvalid_q;
	assign s_axi_rdata            = rdata_q;
	assign s_axi_rresp            = rresp_q;
	assign comparator_change_flag = irq_status_q[crc_pkg::IRQ_CHANGE_BIT];
	assign irq                    = irq_q;

	a_reset_mode_off: assert property (@(posedge aclk) $rose(aresetn) |-> comp_ctrl_q[2:0] == 3'h7)
		else $error("mode not off after reset");
	a_ctrl_write_only: assert property (@(posedge aclk) disable iff (!aresetn)
		!$past(wr_comp) && $past(aresetn) |-> $stable(comp_ctrl_q))
		else $error("comparator control changed without write");
	a_change_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && change_evt && !mode_off |=> irq_status_q[0])
		else $error("change flag not set");
	a_ref_mode_only: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en |=> ref_to_comparators == ($past(comp_ctrl_q[2:0]) == crc_pkg::MODE_REF_INTERNAL))
		else $error("reference routed outside mode 110");
	a_pin_override: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && ladder_ctrl_q[6] |=> !ladder_pin_oe_n)
		else $error("pin not driven");
	sequence s_ladder_write;
		clk_en && wr_lad ##1 clk_en;
	endsequence
	a_tap_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		s_ladder_write |=> ladder_tap_value == $past(wd[3:0], 2))
		else $error("tap not updated");
	a_power_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en |=> ladder_power_on == $past(ladder_ctrl_q[7]))
		else $error("ladder power mismatch");
	// Wake on unmasked event in sleep
	a_wake_in_sleep: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && sleep_active && |(stat_d & irq_mask_q) |=> wake_request)
		else $error("no wake request");
endmodule // crc_top

// *** include/crc_pkg.sv ***
package crc_pkg;
	// Register byte offsets
	localparam logic [3:0] OFS_COMP_CTRL   = 4'h0;
	localparam logic [3:0] OFS_LADDER_CTRL = 4'h4;
	localparam logic [3:0] OFS_IRQ_STATUS  = 4'h8;
	localparam logic [3:0] OFS_IRQ_MASK    = 4'hc;
	// Comparator control fields
	localparam int COMP2_RESULT_BIT = 7;
	localparam int COMP1_RESULT_BIT = 6;
	localparam int COMP2_INV_BIT    = 5;
	localparam int COMP1_INV_BIT    = 4;
	localparam int INPUT_SWITCH_BIT = 3;
	localparam logic [2:0] MODE_REF_INTERNAL = 3'h6;
	localparam logic [2:0] MODE_ALL_OFF      = 3'h7;
	localparam logic [5:0] COMP_CTRL_RESET   = 6'h07;
	// Ladder control fields
	localparam int LADDER_POWER_BIT  = 7;
	localparam int LADDER_PIN_BIT    = 6;
	localparam int LADDER_RANGE_BIT  = 5;
	localparam int LADDER_SOURCE_BIT = 4;
	localparam logic [7:0] LADDER_CTRL_RESET = 8'h00;
	// Interrupt status layout
	localparam int IRQ_CHANGE_BIT = 0;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** test/test_comparator_reference_control.sv ***
module test_comparator_reference_control;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
		$display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
	localparam logic [3:0] A_C = crc_pkg::OFS_COMP_CTRL;
	localparam logic [3:0] A_L = crc_pkg::OFS_LADDER_CTRL;
	localparam logic [3:0] A_S = crc_pkg::OFS_IRQ_STATUS;
	localparam logic [3:0] A_M = crc_pkg::OFS_IRQ_MASK;
	localparam logic [1:0] OK  = crc_pkg::RESP_OKAY;
	logic        aclk = 0, aresetn = 0, sleep = 0, c1 = 0, c2 = 0, f5_dir = 1;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [3:0]  awaddr = 0, araddr = 0, wstrb = 0;
	logic [31:0] wdata = 0, rdata;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [2:0]  mode;
	logic [3:0]  tap;
	logic        analog, ref_c, pwr, pin, oe_n, rng, src, flag, wake, irq;
	logic        inv1, inv2, sw;
	int          num_errors = 0, checks_done = 0, cycles = 0;

	crc_top i_crc_top (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .sleep_active(sleep),
		.comp1_raw(c1), .comp2_raw(c2), .port_f5_direction(f5_dir),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.comparator_mode_field(mode), .comp1_invert(inv1), .comp2_invert(inv2), .input_switch(sw),
		.comp_pins_analog(analog), .ref_to_comparators(ref_c), .ladder_power_on(pwr),
		.ladder_pin_drive(pin), .ladder_pin_oe_n(oe_n), .ladder_range_select(rng),
		.ladder_source_select(src), .ladder_tap_value(tap), .comparator_change_flag(flag),
		.wake_request(wake), .irq(irq));

	always #50 aclk = ~aclk;

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			results();
		end
	end

	task automatic results();
		$display("errors=%0d checks=%0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a; wdata <= {24'h0, d}; wstrb <= 4'h1;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		r = bresp;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask

	task automatic w(input logic [3:0] a, input logic [7:0] d);
		logic [1:0] r;
		wr(a, d, r);
		`CHK(r, OK)
	endtask

	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		`CHK(d, e)
		`CHK(r, OK)
	endtask

	task automatic t_reset();
		rchk(A_C, 32'h07);
		rchk(A_L, 32'h00);
		`CHK(mode, crc_pkg::MODE_ALL_OFF)
		`CHK(analog, 1'b1)
		`CHK({oe_n, irq, ref_c}, 3'b100)
		`CHK({inv2, inv1, sw}, 3'b000)
	endtask

	task automatic t_ladder();
		w(A_L, 8'hb5);
		wait_n(2);
		`CHK({pwr, pin, rng, src, tap}, 8'hb5)
		`CHK(oe_n, 1'b1)
		f5_dir <= 1'b0;
		w(A_L, 8'h4a);
		wait_n(2);
		`CHK({pwr, pin, rng, src, tap}, 8'h4a)
		`CHK(oe_n, 1'b0)
		rchk(A_L, 32'h4a);
		w(A_L, 8'h0f);
		wait_n(2);
		`CHK({pin, oe_n, tap}, 6'h0f)
	endtask

	task automatic t_change();
		w(A_C, 8'h00);
		wait_n(2);
		rchk(A_S, 32'h0);
		c1 <= 1'b1;
		wait_n(3);
		`CHK({flag, irq}, 2'b10)
		w(A_C, 8'hc0);
		rchk(A_C, 32'h40);
		rchk(A_S, 32'h1);
		rchk(A_S, 32'h0);
		w(A_M, 8'h01);
		sleep <= 1'b1;
		c2 <= 1'b1;
		wait_n(3);
		`CHK({irq, wake}, 2'b11)
		sleep <= 1'b0;
		wait_n(2);
		rchk(A_C, 32'hc0);
		rchk(A_S, 32'h1);
		wait_n(2);
		`CHK({irq, wake}, 2'b00)
	endtask

	task automatic t_mode();
		w(A_C, 8'h06);
		wait_n(2);
		`CHK({mode, ref_c}, 4'hd)
		w(A_C, 8'h05);
		wait_n(2);
		`CHK(ref_c, 1'b0)
		w(A_C, 8'h3d);
		wait_n(2);
		`CHK({inv2, inv1, sw, mode}, 6'h3d)
		rchk(A_C, 32'hfd);
	endtask

	task automatic t_sleep_off();
		w(A_C, 8'h3f);
		wait_n(2);
		sleep <= 1'b1;
		c1 <= 1'b0;
		wait_n(3);
		`CHK({flag, irq, wake, ref_c}, 4'h0)
		sleep <= 1'b0;
		rchk(A_C, 32'h3f);
	endtask

	task automatic t_bad();
		logic [31:0] d;
		logic [1:0]  r;
		rd(4'h2, d, r);
		`CHK({r, d}, {crc_pkg::RESP_SLVERR, 32'h0})
		wr(4'h2, 8'h55, r);
		`CHK(r, crc_pkg::RESP_SLVERR)
	endtask

	task automatic t_rereset();
		w(A_L, 8'hff);
		aresetn <= 1'b0;
		wait_n(5);
		aresetn <= 1'b1;
		wait_n(2);
		rchk(A_C, 32'h07);
		rchk(A_L, 32'h00);
		`CHK({pwr, pin, tap}, 6'h00)
		`CHK({inv2, inv1, sw, mode}, 6'h07)
	endtask

	initial begin
		wait_n(5);
		aresetn <= 1'b1;
		wait_n(2);
		t_reset();
		t_ladder();
		t_change();
		t_mode();
		t_sleep_off();
		t_bad();
		t_rereset();
		results();
	end
endmodule // test_comparator_reference_control
